// >>> inc/iei_pkg.sv
// Constants for the incremental encoder interface
package iei_pkg;
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_FLAGS = 8'h01;
  localparam logic [7:0] ADDR_PRESET = 8'h02;
  localparam logic [7:0] ADDR_COUNT = 8'h03;
  localparam logic [7:0] ADDR_CONST = 8'h04;
  localparam logic [7:0] ADDR_LATCH = 8'h05;
  localparam int BIT_POL_A = 0;
  localparam int BIT_POL_B = 1;
  localparam int BIT_POL_N = 2;
  localparam int BIT_SKIP_AB = 3;
  localparam int BIT_CONT = 4;
  localparam int BIT_ONCE = 5;
  localparam int BIT_ACT_EDGE = 6;
  localparam int BIT_INACT_EDGE = 7;
  localparam int BIT_CLEAR = 8;
  localparam int BIT_RAMP = 9;
  localparam int BIT_DECIMAL = 10;
  localparam int BIT_FLAG = 0;
  localparam logic [15:0] CONFIG_RESET = 16'h0000;
  localparam logic [15:0] CONFIG_MASK = 16'h07FF;
  localparam logic [31:0] CONST_RESET = 32'h0001_0000;
  localparam logic [16:0] DIV_BINARY = 17'h10000;
  localparam logic [16:0] DIV_DECIMAL = 17'h02710;
endpackage

// >>> logic/iei_encoder.sv
// Incremental encoder interface: quadrature decode, scaling and index latch
// Operation
// - Config bit 0 sets required A level
// - Config bit 1 sets required B level
// - Config bit 2 sets active N polarity
// - Bit 3 set ignores A and B
// - Bit 4 acts on every index event
// - Bit 5 acts once after mode write
// - Bits 7:6 select level or edge sensitivity
// - Bit 8 clears position at latch
// - Bit 9 also captures ramp position
// - Bit 10 selects divisor 65536 or 10000
// - Flag sets on event, clears on read
// - Flag offered as interrupt source
// - Signed 32-bit position, presettable, readable
// - Signed 16.16 step constant sets direction
// - Step constant resets to 1.0
// - Index event copies position into latch
`timescale 1ns/1ps
module iei_encoder (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Encoder channels
  input wire logic i_enc_a,
  input wire logic i_enc_b,
  input wire logic i_enc_n,
  // Ramp generator position
  input wire logic [31:0] i_ramp_actual_position,
  // Register port
  input wire logic [7:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] i_wdata,
  output logic [31:0] o_rdata,
  // Status outputs
  output logic o_index_irq_src,
  output logic [31:0] o_ramp_latch
);
  typedef enum logic [1:0] {
    IEI_ARM_IDLE = 2'b01,
    IEI_ARM_WAIT = 2'b10
  } iei_arm_e;

  logic [15:0] config_reg, config_next;
  logic [31:0] const_reg, const_next;
  logic [31:0] pos_reg, pos_next;
  logic [16:0] frac_reg, frac_next;
  logic [31:0] latch_reg, latch_next;
  logic [31:0] ramp_reg, ramp_next;
  logic flag_reg, flag_next;
  logic [31:0] rdata_reg, rdata_next;
  logic a_reg, a_next;
  logic b_reg, b_next;
  logic n_act_reg, n_act_next;
  iei_arm_e arm_reg, arm_next;

  logic n_act, ab_ok, idx_event, step, dir_up, act;
  logic [16:0] divisor;
  logic [15:0] frac_abs;
  logic [15:0] int_abs;
  logic [17:0] frac_sum;
  logic carry;
  logic [31:0] delta;
  logic [1:0] sense_sel;

  // Channel qualification
  assign n_act = (i_enc_n == config_reg[iei_pkg::BIT_POL_N]);
  assign ab_ok = config_reg[iei_pkg::BIT_SKIP_AB] ||
    ((i_enc_a == config_reg[iei_pkg::BIT_POL_A]) &&
    (i_enc_b == config_reg[iei_pkg::BIT_POL_B]));

  // Sensitivity select
  assign sense_sel = {config_reg[iei_pkg::BIT_INACT_EDGE],
    config_reg[iei_pkg::BIT_ACT_EDGE]};
  always_comb
  begin
    case (sense_sel)
      2'b00: idx_event = n_act && ab_ok;
      2'b01: idx_event = n_act && !n_act_reg && ab_ok;
      2'b10: idx_event = !n_act && n_act_reg && ab_ok;
      default: idx_event = (n_act != n_act_reg) && ab_ok;
    endcase
  end

  // Quadrature decode: direction from A xor previous B
  assign step = (i_enc_a != a_reg) ^ (i_enc_b != b_reg);
  assign dir_up = i_enc_a ^ b_reg;

  // Channel history
  always_comb
  begin
    a_next = i_enc_a;
    b_next = i_enc_b;
    n_act_next = n_act;
  end

  // Magnitude of constant and scaling
  assign divisor = config_reg[iei_pkg::BIT_DECIMAL] ? iei_pkg::DIV_DECIMAL :
    iei_pkg::DIV_BINARY;
  always_comb
  begin
    logic [31:0] mag;
    mag = const_reg[31] ? (32'h0 - const_reg) : const_reg;
    int_abs = mag[31:16];
    frac_abs = mag[15:0];
  end
  assign frac_sum = {1'b0, frac_reg} + {2'b00, frac_abs};
  assign carry = (frac_sum >= {1'b0, divisor});
  assign delta = {16'h0000, int_abs} + {31'h0, carry};

  // Latch action gating
  assign act = idx_event && (config_reg[iei_pkg::BIT_CONT] ||
    (arm_reg == IEI_ARM_WAIT));

  always_comb
  begin
    config_next = config_reg;
    const_next = const_reg;
    pos_next = pos_reg;
    frac_next = frac_reg;
    latch_next = latch_reg;
    ramp_next = ramp_reg;
    flag_next = flag_reg;
    arm_next = arm_reg;
    rdata_next = rdata_reg;
    if (step)
    begin
      frac_next = carry ? 17'(frac_sum - {1'b0, divisor}) : frac_sum[16:0];
      if (dir_up ^ const_reg[31])
        pos_next = pos_reg + delta;
      else
        pos_next = pos_reg - delta;
    end
    case (arm_reg)
      IEI_ARM_IDLE: arm_next = IEI_ARM_IDLE;
      IEI_ARM_WAIT: if (idx_event) arm_next = IEI_ARM_IDLE;
      default: arm_next = IEI_ARM_IDLE;
    endcase
    if (act)
    begin
      latch_next = pos_reg;
      if (config_reg[iei_pkg::BIT_CLEAR])
      begin
        pos_next = 32'h0000_0000;
        frac_next = 17'h00000;
      end
      if (config_reg[iei_pkg::BIT_RAMP])
        ramp_next = i_ramp_actual_position;
    end
    if (i_wr)
    begin
      case (i_addr)
        iei_pkg::ADDR_CONFIG:
        begin
          config_next = i_wdata[15:0] & iei_pkg::CONFIG_MASK;
          arm_next = i_wdata[iei_pkg::BIT_ONCE] ? IEI_ARM_WAIT : IEI_ARM_IDLE;
        end
        iei_pkg::ADDR_PRESET:
        begin
          pos_next = i_wdata;
          frac_next = 17'h00000;
        end
        iei_pkg::ADDR_CONST: const_next = i_wdata;
        default: ;
      endcase
    end
    if (i_rd)
    begin
      case (i_addr)
        iei_pkg::ADDR_CONFIG: rdata_next = {16'h0000, config_reg};
        iei_pkg::ADDR_FLAGS: rdata_next = {31'h0, flag_reg};
        iei_pkg::ADDR_COUNT: rdata_next = pos_reg;
        iei_pkg::ADDR_CONST: rdata_next = const_reg;
        iei_pkg::ADDR_LATCH: rdata_next = latch_reg;
        default: rdata_next = 32'h0000_0000;
      endcase
      if (i_addr == iei_pkg::ADDR_FLAGS)
        flag_next = 1'b0;
    end
    if (idx_event)
      flag_next = 1'b1;
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      config_reg <= iei_pkg::CONFIG_RESET;
      const_reg <= iei_pkg::CONST_RESET;
      pos_reg <= 32'h0000_0000;
      frac_reg <= 17'h00000;
      latch_reg <= 32'h0000_0000;
      ramp_reg <= 32'h0000_0000;
      flag_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      arm_reg <= IEI_ARM_IDLE;
      a_reg <= 1'b0;
      b_reg <= 1'b0;
      n_act_reg <= 1'b0;
    end
    else
    begin
      config_reg <= config_next;
      const_reg <= const_next;
      pos_reg <= pos_next;
      frac_reg <= frac_next;
      latch_reg <= latch_next;
      ramp_reg <= ramp_next;
      flag_reg <= flag_next;
      rdata_reg <= rdata_next;
      arm_reg <= arm_next;
      a_reg <= a_next;
      b_reg <= b_next;
      n_act_reg <= n_act_next;
    end
  end

  assign o_rdata = rdata_reg;
  assign o_index_irq_src = flag_reg;
  assign o_ramp_latch = ramp_reg;

  // Checks
  sequence s_event_seen;
    idx_event && !i_wr;
  endsequence

  sequence s_flag_read;
    i_rd && i_addr == iei_pkg::ADDR_FLAGS;
  endsequence

  sequence s_once_write;
    i_wr && i_addr == iei_pkg::ADDR_CONFIG && i_wdata[iei_pkg::BIT_ONCE];
  endsequence

  chk_flag_set: assert property (@(posedge i_clk) disable iff (i_rst)
    idx_event |=> flag_reg)
    else $error("index flag not set");
  chk_flag_clear: assert property (@(posedge i_clk) disable iff (i_rst)
    (s_flag_read ##0 !idx_event) |=> !flag_reg)
    else $error("index flag not cleared by read");
  chk_latch_copy: assert property (@(posedge i_clk) disable iff (i_rst)
    act |=> latch_reg == $past(pos_reg))
    else $error("latch missed position");
  chk_clear_pos: assert property (@(posedge i_clk) disable iff (i_rst)
    (act && config_reg[iei_pkg::BIT_CLEAR] && !i_wr) |=> pos_reg == 32'h0)
    else $error("position not cleared");
  chk_ramp_cap: assert property (@(posedge i_clk) disable iff (i_rst)
    (act && config_reg[iei_pkg::BIT_RAMP]) |=> o_ramp_latch == $past(i_ramp_actual_position))
    else $error("ramp position not captured");
  chk_once_only: assert property (@(posedge i_clk) disable iff (i_rst)
    (s_event_seen ##0 !config_reg[iei_pkg::BIT_CONT]) |=> arm_reg == IEI_ARM_IDLE && !act)
    else $error("single latch repeated");
  chk_preset_pos: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_wr && i_addr == iei_pkg::ADDR_PRESET) |=> pos_reg == $past(i_wdata))
    else $error("preset not applied");
  chk_no_act: assert property (@(posedge i_clk) disable iff (i_rst)
    (!idx_event) |=> latch_reg == $past(latch_reg))
    else $error("latch moved without event");
  chk_gate_ab: assert property (@(posedge i_clk) disable iff (i_rst)
    (!config_reg[iei_pkg::BIT_SKIP_AB] && i_enc_a != config_reg[iei_pkg::BIT_POL_A]) |-> !idx_event)
    else $error("event despite A mismatch");
  chk_gate_b: assert property (@(posedge i_clk) disable iff (i_rst)
    (!config_reg[iei_pkg::BIT_SKIP_AB] && i_enc_b != config_reg[iei_pkg::BIT_POL_B]) |-> !idx_event)
    else $error("event despite B mismatch");
  chk_level_event: assert property (@(posedge i_clk) disable iff (i_rst)
    (sense_sel == 2'b00 && config_reg[iei_pkg::BIT_SKIP_AB] &&
    i_enc_n == config_reg[iei_pkg::BIT_POL_N]) |-> idx_event)
    else $error("level event missed");
  chk_pol_n: assert property (@(posedge i_clk) disable iff (i_rst)
    (sense_sel == 2'b00 && idx_event) |-> i_enc_n == config_reg[iei_pkg::BIT_POL_N])
    else $error("event at inactive index level");
  chk_rise_event: assert property (@(posedge i_clk) disable iff (i_rst)
    (sense_sel == 2'b01 && idx_event) |-> n_act && !$past(n_act))
    else $error("active edge event without edge");
  chk_fall_event: assert property (@(posedge i_clk) disable iff (i_rst)
    (sense_sel == 2'b10 && idx_event) |-> !n_act && $past(n_act))
    else $error("inactive edge event without edge");
  chk_both_event: assert property (@(posedge i_clk) disable iff (i_rst)
    (sense_sel == 2'b11 && idx_event) |-> n_act != $past(n_act))
    else $error("both edge event without edge");
  chk_cont_act: assert property (@(posedge i_clk) disable iff (i_rst)
    (idx_event && config_reg[iei_pkg::BIT_CONT]) |-> act)
    else $error("continuous latch skipped");
  chk_once_arm: assert property (@(posedge i_clk) disable iff (i_rst)
    s_once_write |=> arm_reg == IEI_ARM_WAIT)
    else $error("single latch not armed");
  chk_const_write: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_wr && i_addr == iei_pkg::ADDR_CONST) |=> const_reg == $past(i_wdata))
    else $error("constant not written");
  chk_step_up: assert property (@(posedge i_clk) disable iff (i_rst)
    (step && dir_up && !act && !i_wr && const_reg == iei_pkg::CONST_RESET &&
    !config_reg[iei_pkg::BIT_DECIMAL] && !frac_reg[16]) |=> pos_reg == $past(pos_reg) + 32'h0000_0001)
    else $error("forward step not counted");
  chk_step_down: assert property (@(posedge i_clk) disable iff (i_rst)
    (step && !dir_up && !act && !i_wr && const_reg == iei_pkg::CONST_RESET &&
    !config_reg[iei_pkg::BIT_DECIMAL] && !frac_reg[16]) |=> pos_reg == $past(pos_reg) - 32'h0000_0001)
    else $error("backward step not counted");
  chk_no_step: assert property (@(posedge i_clk) disable iff (i_rst)
    (!step && !act && !i_wr) |=> pos_reg == $past(pos_reg))
    else $error("position moved without step");
  chk_flag_hold: assert property (@(posedge i_clk) disable iff (i_rst)
    (!idx_event && !(i_rd && i_addr == iei_pkg::ADDR_FLAGS)) |=> flag_reg == $past(flag_reg))
    else $error("index flag changed without cause");
  chk_read_count: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_rd && i_addr == iei_pkg::ADDR_COUNT) |=> o_rdata == $past(pos_reg))
    else $error("position read wrong");
  chk_ramp_hold: assert property (@(posedge i_clk) disable iff (i_rst)
    !(act && config_reg[iei_pkg::BIT_RAMP]) |=> o_ramp_latch == $past(o_ramp_latch))
    else $error("ramp latch moved without capture");
endmodule

// >>> verif/iei_enc_model.sv
// Behavioural quadrature encoder with index channel
`timescale 1ns/1ps
module iei_enc_model (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Request: 1 forward, 2 back, 3 toggle index
  input wire logic [1:0] i_cmd,
  // Encoder channels
  output logic o_a,
  output logic o_b,
  output logic o_n
);
  logic [2:0] st_reg;
  assign {o_n, o_b, o_a} = {st_reg[2:1], ^st_reg[1:0]};
  always_ff @(posedge i_clk or posedge i_rst)
    if (i_rst)
      st_reg <= 3'h0;
    else
      st_reg <= {st_reg[2] ^ (i_cmd == 2'h3), st_reg[1:0] + {i_cmd == 2'h2, ^i_cmd}};
endmodule

// >>> verif/incremental_encoder_interface_test.sv
// Self-checking bench for the incremental encoder interface
`timescale 1ns/1ps
module incremental_encoder_interface_test;
  logic i_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, a, b, n, irq;
  logic [1:0] cmd = 2'h0;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0, o_rdata, rlat;
  logic [31:0] ramp = 32'h0000ABCD;
  int failures = 0, checks = 0;
  iei_enc_model enc (.i_clk(i_clk), .i_rst(i_rst), .i_cmd(cmd), .o_a(a), .o_b(b), .o_n(n));
  iei_encoder dut (.i_clk(i_clk), .i_rst(i_rst), .i_enc_a(a), .i_enc_b(b), .i_enc_n(n),
    .i_ramp_actual_position(ramp), .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd),
    .i_wdata(i_wdata), .o_rdata(o_rdata), .o_index_irq_src(irq), .o_ramp_latch(rlat));
  initial
  begin
    forever #10 i_clk = ~i_clk;
  end
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks++;
    failures += (s !== e);
    if (s !== e)
      $display("mismatch %s expected %h seen %h", nm, e, s);
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= ad;
    i_wdata <= d;
    @(posedge i_clk) i_wr <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] ad, input logic [31:0] e);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= ad;
    @(posedge i_clk) i_rd <= 1'b0;
    #1 chk($sformatf("reg%0h", ad), o_rdata, e);
  endtask
  task automatic go(input logic [1:0] c, input int k);
    repeat (k)
    begin
      @(posedge i_clk) cmd <= c;
      @(posedge i_clk) cmd <= 2'h0;
      repeat (3) @(posedge i_clk);
    end
  endtask
  task automatic t_count;
    rc(8'h4, 32'h10000);
    wr(8'h2, 32'h0);
    go(2'h1, 4);
    go(2'h2, 6);
    rc(8'h3, 32'hFFFFFFFE);
    wr(8'h4, 32'hFFFF0000);
    go(2'h1, 3);
    rc(8'h3, 32'hFFFFFFFB);
    wr(8'h0, 32'h400);
    wr(8'h4, 32'h1388);
    wr(8'h2, 32'h0);
    go(2'h1, 2);
    rc(8'h3, 32'h1);
  endtask
  task automatic t_index;
    wr(8'h0, 32'hFB5C);
    rc(8'h0, 32'h35C);
    wr(8'h2, 32'h7);
    rc(8'h1, 32'h1);
    chk("irq_src", {31'h0, irq}, 32'h0);
    go(2'h3, 2);
    chk("ramp_latch", rlat, 32'h0000ABCD);
    chk("irq_src", {31'h0, irq}, 32'h1);
    rc(8'h5, 32'h7);
    rc(8'h3, 32'h0);
    rc(8'h1, 32'h1);
    rc(8'h1, 32'h0);
  endtask
  task automatic t_qual;
    logic [15:0] cfg [7] = '{16'h55, 16'h54, 16'h57, 16'h5E, 16'h95, 16'hD5, 16'h11};
    logic ex [7] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
    @(posedge i_clk) ramp <= 32'h00001234;
    go(2'h1, 2);
    for (int i = 0; i < 7; i++)
    begin
      wr(8'h0, {16'h0, cfg[i]});
      go(2'h3, 2);
      rc(8'h1, {31'h0, ex[i]});
    end
    wr(8'h0, 32'h165);
    wr(8'h2, 32'h5);
    go(2'h3, 2);
    rc(8'h3, 32'h0);
    wr(8'h2, 32'h9);
    go(2'h3, 2);
    rc(8'h3, 32'h9);
    rc(8'h5, 32'h5);
    chk("ramp_latch", rlat, 32'h0000ABCD);
  endtask
  task automatic finish_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(posedge i_clk);
    i_rst <= 1'b0;
    t_count;
    t_index;
    t_qual;
    finish_test;
  end
  initial
  begin
    #200us;
    failures++;
    finish_test;
  end
endmodule
